/* File: hdl/wsc_pkg.sv */
// wsc_pkg: constants for the wake source control register bank
package wsc_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [6:0] WSC_ADDR_INT = 7'h06;
	localparam logic [6:0] WSC_ADDR_EXT = 7'h07;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int WSC_BIT_T2_WK = 7;
	localparam int WSC_BIT_T1_WK = 6;
	localparam int WSC_BIT_STOP_WD_HI = 2;
	localparam int WSC_BIT_INT_ALL = 7;
	localparam int WSC_BIT_MEAS = 5;
	localparam int WSC_BIT_HV3 = 2;
	localparam int WSC_BIT_HV2 = 1;
	localparam int WSC_BIT_HV1 = 0;
	// ----------------------------------------
	// implemented bits, reset, restart, fail-safe
	// ----------------------------------------
	localparam logic [7:0] WSC_INT_MASK = 8'hC4;
	localparam logic [7:0] WSC_EXT_MASK = 8'hA7;
	localparam logic [7:0] WSC_INT_RESET = 8'h00;
	localparam logic [7:0] WSC_EXT_RESET = 8'h07;
	localparam logic [7:0] WSC_INT_RESTART_KEEP = 8'hC0;
	localparam logic [7:0] WSC_EXT_RESTART_KEEP = 8'hA7;
	localparam logic [7:0] WSC_EXT_FS_KEEP = 8'hA0;
	localparam logic [7:0] WSC_EXT_FS_SET = 8'h07;
	// ----------------------------------------
	// bus transceiver modes and serial frame
	// ----------------------------------------
	localparam logic [1:0] WSC_CAN_WAKE_LOW = 2'h1;
	localparam logic [4:0] WSC_FRAME_BITS = 5'h10;
	localparam logic [4:0] WSC_HDR_BITS = 5'h08;
	localparam int WSC_ADDR_W = 7;
	localparam int WSC_WR_BIT = 7;
endpackage

/* File: hdl/wsc_regs.sv */
// wsc_regs: wake source control registers behind the serial configuration port
`timescale 1ns/100ps
`default_nettype none
module wsc_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// serial configuration port pins
	input wire logic spi_csn_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// chip events
	input wire logic soft_reset,
	input wire logic restart_event,
	input wire logic fail_safe_entry,
	input wire logic normal_mode,
	// hardware update of stop watchdog off bit hi
	input wire logic hw_stop_wd_hi_we,
	input wire logic hw_stop_wd_hi_val,
	// watchdog register bit lo and bus transceiver mode
	input wire logic stop_watchdog_off_bit_lo,
	input wire logic [2:0] can_mode,
	// control outputs
	output logic second_timer_wake_enable,
	output logic first_timer_wake_enable,
	output logic [1:0] stop_watchdog_off,
	output logic int_all_status,
	output logic measure_active,
	output logic ignore_level_12,
	output logic [2:0] hv_wake_enable,
	output logic can_wake_source,
	output logic bus_ctrl_force_wake
);
	import wsc_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] csn_sync;
	logic [2:0] sclk_sync;
	logic [1:0] sdi_sync;
	logic csn_last;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			csn_sync <= 2'h3;
			sclk_sync <= 3'h0;
			sdi_sync <= 2'h0;
			csn_last <= 1'b1;
		end else begin
			csn_sync <= {csn_sync[0], spi_csn_n};
			sclk_sync <= {sclk_sync[1:0], spi_sclk};
			sdi_sync <= {sdi_sync[0], spi_sdi};
			csn_last <= csn_sync[1];
		end
	end
	logic sclk_rise;
	logic frame_end;
	assign sclk_rise = sclk_sync[1] & ~sclk_sync[2] & ~csn_sync[1];
	assign frame_end = csn_sync[1] & ~csn_last;

	// ----------------------------------------
	// frame shifter
	// ----------------------------------------
	logic [15:0] frame;
	logic [4:0] bit_cnt;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			frame <= 16'h0000;
			bit_cnt <= 5'h00;
		end else if (csn_sync[1]) begin
			bit_cnt <= 5'h00;
		end else if (sclk_rise) begin
			frame <= {sdi_sync[1], frame[15:1]};
			if (bit_cnt != WSC_FRAME_BITS + 5'h01)
				bit_cnt <= bit_cnt + 5'h01;
		end
	end

	logic [6:0] wr_addr;
	logic wr_flag;
	logic sw_wr_int;
	logic sw_wr_ext;
	assign wr_addr = frame[WSC_ADDR_W-1:0];
	assign wr_flag = frame[WSC_WR_BIT];
	assign sw_wr_int = frame_end & (bit_cnt == WSC_FRAME_BITS) & wr_flag & (wr_addr == WSC_ADDR_INT);
	assign sw_wr_ext = frame_end & (bit_cnt == WSC_FRAME_BITS) & wr_flag & (wr_addr == WSC_ADDR_EXT);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] int_reg;
	logic [7:0] ext_reg;
	always_ff @(posedge sys_clk) begin
		if (!rst_n || soft_reset) begin
			int_reg <= WSC_INT_RESET;
		end else if (restart_event) begin
			int_reg <= int_reg & WSC_INT_RESTART_KEEP;
		end else begin
			if (sw_wr_int)
				int_reg <= frame[15:8] & WSC_INT_MASK;
			if (hw_stop_wd_hi_we)
				int_reg[WSC_BIT_STOP_WD_HI] <= hw_stop_wd_hi_val;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n || soft_reset) begin
			ext_reg <= WSC_EXT_RESET;
		end else if (restart_event) begin
			ext_reg <= ext_reg & WSC_EXT_RESTART_KEEP;
		end else if (fail_safe_entry) begin
			ext_reg <= (ext_reg & WSC_EXT_FS_KEEP) | WSC_EXT_FS_SET;
		end else if (sw_wr_ext) begin
			ext_reg <= frame[15:8] & WSC_EXT_MASK;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [7:0] rd_val;
	logic [7:0] rd_shift;
	always_comb begin
		rd_val = 8'h00;
		if (frame[15:9] == WSC_ADDR_INT)
			rd_val = int_reg & WSC_INT_MASK;
		else if (frame[15:9] == WSC_ADDR_EXT)
			rd_val = ext_reg & WSC_EXT_MASK;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_shift <= 8'h00;
			spi_sdo <= 1'b0;
		end else if (sclk_rise && bit_cnt == WSC_HDR_BITS - 5'h01) begin
			rd_shift <= {1'b0, rd_val[7:1]};
			spi_sdo <= rd_val[0];
		end else if (sclk_rise && bit_cnt >= WSC_HDR_BITS) begin
			rd_shift <= {1'b0, rd_shift[7:1]};
			spi_sdo <= rd_shift[0];
		end
	end
	assign spi_sdo_oe = ~csn_sync[1];

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	logic meas;
	assign meas = ext_reg[WSC_BIT_MEAS];
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			second_timer_wake_enable <= 1'b0;
			first_timer_wake_enable <= 1'b0;
			stop_watchdog_off <= 2'h0;
			int_all_status <= 1'b0;
			measure_active <= 1'b0;
			ignore_level_12 <= 1'b0;
			hv_wake_enable <= 3'h0;
			can_wake_source <= 1'b0;
			bus_ctrl_force_wake <= 1'b0;
		end else begin
			second_timer_wake_enable <= int_reg[WSC_BIT_T2_WK];
			first_timer_wake_enable <= int_reg[WSC_BIT_T1_WK];
			stop_watchdog_off <= {int_reg[WSC_BIT_STOP_WD_HI], stop_watchdog_off_bit_lo};
			int_all_status <= ext_reg[WSC_BIT_INT_ALL];
			measure_active <= meas & normal_mode;
			ignore_level_12 <= meas;
			hv_wake_enable[2] <= ext_reg[WSC_BIT_HV3];
			hv_wake_enable[1] <= ext_reg[WSC_BIT_HV2] & ~meas;
			hv_wake_enable[0] <= ext_reg[WSC_BIT_HV1] & ~meas;
			can_wake_source <= (can_mode[1:0] == WSC_CAN_WAKE_LOW);
			bus_ctrl_force_wake <= fail_safe_entry & ~restart_event & ~soft_reset;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	int_reserved_a: assert property ((int_reg & ~WSC_INT_MASK) == 8'h00)
		else $error("internal register reserved bit set");
	ext_reserved_a: assert property ((ext_reg & ~WSC_EXT_MASK) == 8'h00)
		else $error("external register reserved bit set");
	soft_reset_a: assert property (soft_reset |=> ext_reg == WSC_EXT_RESET && int_reg == 8'h00)
		else $error("soft reset values wrong");
	restart_int_a: assert property (restart_event && !soft_reset
		|=> int_reg == ($past(int_reg) & WSC_INT_RESTART_KEEP))
		else $error("internal restart value wrong");
	fail_safe_a: assert property (fail_safe_entry && !restart_event && !soft_reset
		|=> ext_reg[2:0] == 3'h7 && ext_reg[6] == 1'b0 && ext_reg[7] == $past(ext_reg[7])
		&& bus_ctrl_force_wake)
		else $error("fail-safe forcing wrong");
	hw_wins_a: assert property (hw_stop_wd_hi_we && !restart_event && !soft_reset
		|=> int_reg[WSC_BIT_STOP_WD_HI] == $past(hw_stop_wd_hi_val))
		else $error("hardware update lost");
	meas_gate_a: assert property (ext_reg[WSC_BIT_MEAS] && !$changed(ext_reg)
		|=> hv_wake_enable[1:0] == 2'h0)
		else $error("inputs one/two wake while measuring");
	hv_follow_a: assert property ($stable(ext_reg)
		|=> hv_wake_enable[2] == $past(ext_reg[WSC_BIT_HV3]))
		else $error("input three enable mismatch");
	timers_a: assert property ($stable(int_reg)
		|=> {second_timer_wake_enable, first_timer_wake_enable} == $past(int_reg[7:6]))
		else $error("timer wake enables mismatch");
	int_scope_a: assert property ($stable(ext_reg)
		|=> int_all_status == $past(ext_reg[WSC_BIT_INT_ALL]))
		else $error("interrupt scope mismatch");

	sw_write_c: cover property (sw_wr_ext ##1 ext_reg[WSC_BIT_MEAS]);
	fail_safe_c: cover property (fail_safe_entry ##1 bus_ctrl_force_wake);
	restart_c: cover property (sw_wr_ext ##[1:20] restart_event);
	hw_sw_clash_c: cover property (sw_wr_int && hw_stop_wd_hi_we);
endmodule
`default_nettype wire

/* File: tb/wsc_host_model.sv */
// wsc_host_model: host side of the serial configuration port
`timescale 1ns/100ps
`default_nettype none
module wsc_host_model (
	// clock and serial port
	input wire logic sys_clk,
	output logic spi_csn_n = 1'b1,
	output logic spi_sclk = 1'b0,
	output logic spi_sdi = 1'b0,
	input wire logic spi_sdo
);
	task automatic half();
		repeat (5) @(posedge sys_clk);
		#1;
	endtask
	task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
		spi_csn_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			spi_sdi = tx[i];
			half();
			spi_sclk = 1'b1;
			rx = {spi_sdo, rx[7:1]};
			half();
			spi_sclk = 1'b0;
		end
		spi_csn_n = 1'b1;
		spi_sdi = ~spi_sdi;
		half();
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_wsc_regs.sv */
// tb_wsc_regs: self-checking bench for the wake source control registers
`timescale 1ns/100ps
`default_nettype none
module tb_wsc_regs;
	import wsc_pkg::*;
	logic sys_clk, rst_n, srst, rse, fse, nm, hwe, hwv, wdl;
	logic [2:0] cm;
	logic [7:0] d;
	wire logic csn, sclk, sdi, sdo, oe, t2, t1, ia, ma, il, cws, fw;
	wire logic [1:0] swd;
	wire logic [2:0] hv;
	int mismatches, comparisons;
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	wsc_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_csn_n(csn), .spi_sclk(sclk),
		.spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .soft_reset(srst), .restart_event(rse),
		.fail_safe_entry(fse), .normal_mode(nm), .hw_stop_wd_hi_we(hwe), .hw_stop_wd_hi_val(hwv),
		.stop_watchdog_off_bit_lo(wdl), .can_mode(cm), .second_timer_wake_enable(t2),
		.first_timer_wake_enable(t1), .stop_watchdog_off(swd), .int_all_status(ia),
		.measure_active(ma), .ignore_level_12(il), .hv_wake_enable(hv), .can_wake_source(cws),
		.bus_ctrl_force_wake(fw));
	wsc_host_model host (.sys_clk(sys_clk), .spi_csn_n(csn), .spi_sclk(sclk), .spi_sdi(sdi),
		.spi_sdo(sdo));
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
		host.frame({8'h00, 1'b0, a}, d);
		chk_pin(d, exp);
	endtask
	task automatic step(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task automatic ev(input logic [3:0] e);
		{srst, rse, fse, hwe} = e;
		step(1);
		{srst, rse, fse, hwe} = 4'h0;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge sys_clk);
		mismatches++;
		finish_test();
	end
	initial begin
		{rst_n, srst, rse, fse, nm, hwe, hwv, wdl, cm} = 11'h058;
		step(12);
		rst_n = 1'b1;
		step(4);
		fork
			chk_reg(WSC_ADDR_INT, 8'h00);
			begin
				step(20);
				chk_pin({7'h00, oe}, 8'h01);
			end
		join
		chk_reg(WSC_ADDR_EXT, 8'h07);
		chk_pin({3'h0, ia, il, hv}, 8'h07);
		host.frame({8'hFF, 1'b1, WSC_ADDR_INT}, d);
		host.frame({8'hFF, 1'b1, WSC_ADDR_EXT}, d);
		chk_reg(WSC_ADDR_INT, 8'hC4);
		chk_reg(WSC_ADDR_EXT, 8'hA7);
		chk_pin({t2, t1, swd, ia, ma, il, 1'b0}, 8'hFE);
		chk_pin({5'h00, hv}, 8'h04);
		{nm, wdl} = 2'h0;
		step(2);
		chk_pin({6'h00, ma, swd[0]}, 8'h00);
		chk_pin({7'h00, oe}, 8'h00);
		{nm, wdl} = 2'h3;
		for (int k = 0; k < 3; k++) begin
			host.frame({8'h01 << k, 1'b1, WSC_ADDR_EXT}, d);
			step(8);
			chk_pin({5'h00, hv}, 8'h01 << k);
		end
		$display("test fields done");
		host.frame({8'hA4, 1'b1, WSC_ADDR_EXT}, d);
		ev(4'h4);
		chk_reg(WSC_ADDR_INT, 8'hC0);
		chk_reg(WSC_ADDR_EXT, 8'hA4);
		ev(4'h1);
		chk_reg(WSC_ADDR_INT, 8'hC4);
		ev(4'h2);
		chk_pin({7'h00, fw}, 8'h01);
		step(1);
		chk_pin({7'h00, fw}, 8'h00);
		chk_reg(WSC_ADDR_EXT, 8'hA7);
		ev(4'h8);
		chk_reg(WSC_ADDR_INT, 8'h00);
		chk_reg(WSC_ADDR_EXT, 8'h07);
		fork
			host.frame({8'h00, 1'b1, WSC_ADDR_INT}, d);
			begin
				@(posedge csn);
				step(2);
				ev(4'h1);
			end
		join
		chk_reg(WSC_ADDR_INT, 8'h04);
		for (int m = 0; m < 8; m++) begin
			cm = m[2:0];
			step(8);
			chk_pin({7'h00, cws}, {7'h00, m[1:0] == 2'b01});
		end
		$display("test events done");
		finish_test();
	end
endmodule
`default_nettype wire
